// [dv/qvr_bridge_model.sv]
// Purpose: coil and comparator of the power bridge
// Assumes: current rises only while the bridge is on
// Notes: target is given in on cycles, 0 trips at once
`timescale 1ns/1ps
module qvr_bridge_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // bridge
  input wire logic pwm_on_in,
  input wire logic [10:0] target_in,
  // comparator
  output logic current_reached_out
);
  logic [10:0] run_ff;
  // coil decays in the off phase, so each on phase starts from zero
  always_ff @(posedge clk_in) begin
    if (reset_in || !pwm_on_in) begin
      run_ff <= 11'h000;
    end else if (run_ff != 11'h7FF) begin
      run_ff <= run_ff + 11'h001;
    end
  end
  always_ff @(posedge clk_in) begin
    current_reached_out <= !reset_in && pwm_on_in && run_ff >= target_in;
  end
endmodule

// [dv/qvr_reg_asserts.sv]
// Purpose: port checks of the quiet pwm regulator
// Assumes: one clock, sync reset, bus master holds requests
// Notes: ctrl and gain are shadowed from accepted bus writes
`timescale 1ns/1ps
module qvr_reg_asserts #(
  parameter int STANDSTILL_CLKS = qvr_pkg::STANDSTILL_CLKS_DEF
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // bus
  input wire logic [qvr_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // pins and bridge
  input wire logic step_in,
  input wire logic current_reached_in,
  input wire logic pwm_on_out,
  input wire logic freewheel_out,
  input wire logic measure_enable_out,
  input wire logic quiet_active_out,
  input wire logic [7:0] pwm_scale_out
);
  import qvr_pkg::*;
  logic auto_ff;
  logic fw_ff;
  logic [7:0] grad_ff;
  logic [7:0] prev_ff;
  logic [7:0] dlt;
  logic wr;
  assign wr = avs_write_in && !avs_waitrequest_out;
  assign dlt = (pwm_scale_out > prev_ff) ? pwm_scale_out - prev_ff : prev_ff - pwm_scale_out;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      auto_ff <= CTRL_RESET[CTRL_AUTO_BIT];
      fw_ff <= CTRL_RESET[CTRL_FREEWHEEL_BIT];
    end else if (wr && avs_address_in == ADDR_CTRL) begin
      auto_ff <= avs_writedata_in[CTRL_AUTO_BIT];
      fw_ff <= avs_writedata_in[CTRL_FREEWHEEL_BIT];
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      grad_ff <= GRAD_RESET;
    end else if (wr && avs_address_in == ADDR_GRAD) begin
      grad_ff <= avs_writedata_in[7:0];
    end
  end
  always_ff @(posedge clk_in) begin
    prev_ff <= pwm_scale_out;
  end
  // ****
  // properties
  // ****
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  property p_one_wait;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest longer than one cycle");
  property p_ff_quiet;
    !auto_ff && !$past(auto_ff) && !$past(auto_ff, 2) |-> !measure_enable_out;
  endproperty
  a_ff_quiet: assert property (p_ff_quiet) else $error("sampling in feed-forward");
  property p_meas_mode;
    measure_enable_out |-> quiet_active_out || $past(quiet_active_out);
  endproperty
  a_meas_mode: assert property (p_meas_mode) else $error("sampling outside quiet mode");
  property p_blank;
    measure_enable_out |-> $past(pwm_on_out, 8);
  endproperty
  a_blank: assert property (p_blank) else $error("sampling inside blanking");
  // three cycles of slack: both outputs are registered stages of the mode
  property p_other_off;
    !quiet_active_out && !$past(quiet_active_out) && !$past(quiet_active_out, 2) |-> !pwm_on_out;
  endproperty
  a_other_off: assert property (p_other_off) else $error("pwm running in other mode");
  property p_hold;
    !quiet_active_out && !$past(quiet_active_out) && !$past(quiet_active_out, 2) |-> $stable(pwm_scale_out);
  endproperty
  a_hold: assert property (p_hold) else $error("scale moved in other mode");
  property p_gain;
    auto_ff && $past(auto_ff, 2) && quiet_active_out && $past(quiet_active_out) && $past(quiet_active_out, 2)
      && grad_ff == $past(grad_ff, 2) |-> dlt <= grad_ff;
  endproperty
  a_gain: assert property (p_gain) else $error("scale step above gain");
  property p_fw;
    freewheel_out |-> (fw_ff || $past(fw_ff)) && (quiet_active_out || $past(quiet_active_out));
  endproperty
  a_fw: assert property (p_fw) else $error("freewheel without enable");
endmodule
bind qvr_quiet_pwm_regulator qvr_reg_asserts #(.STANDSTILL_CLKS(STANDSTILL_CLKS)) qvr_reg_asserts_inst (
  .clk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_readdata_out, .avs_waitrequest_out, .step_in, .current_reached_in, .pwm_on_out,
  .freewheel_out, .measure_enable_out, .quiet_active_out, .pwm_scale_out
);

// [dv/tb.sv]
// Purpose: self-checking bench of the quiet pwm regulator
// Assumes: avalon master with held requests, 40 MHz clock
// Notes: short standstill timeout keeps the run small
`timescale 1ns/1ps
module tb;
  import qvr_pkg::*;
  localparam int SCLK = 2000;
  localparam logic [10:0] DIV [4] = '{PWM_DIV_00, PWM_DIV_01, PWM_DIV_10, PWM_DIV_11};
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [ADDR_W-1:0] avs_address_in = 3'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic step_in = 1'b0;
  logic current_reached_in;
  logic pwm_on_out;
  logic freewheel_out;
  logic measure_enable_out;
  logic quiet_active_out;
  logic [7:0] pwm_scale_out;
  logic [10:0] target = 11'h7FF;
  logic last_on = 1'b0;
  logic [31:0] rd;
  int miscompares = 0;
  int samples_checked = 0;
  realtime t0;
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) last_on <= pwm_on_out;
  qvr_quiet_pwm_regulator #(.STANDSTILL_CLKS(SCLK)) qvr_quiet_pwm_regulator_inst (
    .clk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out, .step_in, .current_reached_in, .pwm_on_out,
    .freewheel_out, .measure_enable_out, .quiet_active_out, .pwm_scale_out
  );
  qvr_bridge_model qvr_bridge_model_inst (
    .clk_in, .reset_in, .pwm_on_in(pwm_on_out), .target_in(target), .current_reached_out(current_reached_in)
  );
  // ****
  // tasks
  // ****
  task end_sim();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task fail_if(input logic c);
    if (c) begin
      miscompares++;
      end_sim();
    end
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    fail_if(n >= 20);
  endtask
  task on_rise();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (!(pwm_on_out === 1'b1 && last_on === 1'b0) && n < 3000);
    fail_if(n >= 3000);
  endtask
  task steps(input int per, input int n);
    repeat (n) begin
      @(posedge clk_in);
      step_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      step_in <= 1'b0;
      repeat (per - 5) @(posedge clk_in);
    end
  endtask
  task scale_is(input logic [7:0] v);
    check({24'h0000_00, pwm_scale_out}, {24'h0000_00, v});
  endtask
  task scale_in(input logic [7:0] lo, input logic [7:0] hi);
    check({31'h0000_0000, pwm_scale_out >= lo && pwm_scale_out <= hi}, 32'h0000_0001);
  endtask
  initial begin
    int n;
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    // ****
    // register map
    // ****
    bus(1'b0, ADDR_CTRL, 32'h0000_0000);
    check(rd, 32'(CTRL_RESET));
    bus(1'b0, ADDR_GRAD, 32'h0000_0000);
    check(rd, 32'(GRAD_RESET));
    bus(1'b0, ADDR_AMPL, 32'h0000_0000);
    check(rd, 32'(AMPL_RESET));
    bus(1'b0, ADDR_THRS, 32'h0000_0000);
    check(rd, 32'(THRS_RESET));
    bus(1'b1, ADDR_TSTEP, 32'h0000_0000);
    bus(1'b0, ADDR_TSTEP, 32'h0000_0000);
    check(rd, 32'h000F_FFFF);
    bus(1'b0, 3'h6, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    bus(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
    bus(1'b0, ADDR_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_003F);
    repeat (8) @(posedge clk_in);
    check({31'h0000_0000, freewheel_out}, 32'h0000_0001);
    // ****
    // feed-forward: divisors, comparator ignored, velocity term
    // ****
    target <= 11'h000;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, ADDR_CTRL, 32'(c << 1));
      on_rise();
      on_rise();
      t0 = $realtime;
      on_rise();
      check(32'(int'(($realtime - t0) / 25.0)), 32'(DIV[c]));
      scale_is(AMPL_RESET);
    end
    bus(1'b1, ADDR_GRAD, 32'h0000_0008);
    steps(1000, 6);
    scale_is(8'h82);
    bus(1'b1, ADDR_AMPL, 32'h0000_00F0);
    bus(1'b1, ADDR_GRAD, 32'h0000_00FF);
    steps(200, 8);
    scale_is(8'hFF);
    // ****
    // automatic regulation at standstill
    // ****
    bus(1'b1, ADDR_GRAD, 32'h0000_0010);
    target <= 11'h7FF;
    bus(1'b1, ADDR_CTRL, 32'h0000_0007);
    repeat (34000) @(posedge clk_in);
    scale_is(8'hFF);
    target <= 11'h000;
    repeat (8200) @(posedge clk_in);
    // below the blanking time nothing is measured, so it cannot stay at zero
    scale_in(8'h00, 8'h2F);
    bus(1'b1, ADDR_GRAD, 32'h0000_0004);
    target <= 11'h0CD;
    repeat (16000) @(posedge clk_in);
    scale_in(8'h78, 8'h88);
    bus(1'b0, ADDR_STATUS, 32'h0000_0000);
    check({31'h0000_0000, rd[STAT_INIT_BIT]}, 32'h0000_0001);
    // ****
    // velocity threshold and return
    // ****
    bus(1'b1, ADDR_AMPL, 32'h0000_0040);
    bus(1'b1, ADDR_THRS, 32'h0000_05DC);
    steps(500, 5);
    check({31'h0000_0000, quiet_active_out}, 32'h0000_0000);
    n = 0;
    while (quiet_active_out !== 1'b1 && n < 4000) begin
      @(posedge clk_in);
      n++;
    end
    fail_if(n >= 4000);
    repeat (2) @(posedge clk_in);
    scale_is(8'h40);
    end_sim();
  end
endmodule

// [pkg/qvr_pkg.sv]
// Purpose: shared constants and types of the quiet voltage pwm regulator
// Assumes: word addressed avalon-mm slave with 32-bit data
// Notes: offsets are word indices on the register bus
package qvr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_GRAD = 3'h1;
  localparam logic [2:0] ADDR_AMPL = 3'h2;
  localparam logic [2:0] ADDR_THRS = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  localparam logic [2:0] ADDR_TSTEP = 3'h5;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_FREQ_LSB = 1;
  localparam int CTRL_FREEWHEEL_BIT = 3;
  localparam int CTRL_BLANK_LSB = 4;
  localparam int STAT_QUIET_BIT = 8;
  localparam int STAT_STILL_BIT = 9;
  localparam int STAT_INIT_BIT = 10;
  localparam int TSTEP_W = 20;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [5:0] CTRL_RESET = 6'h01;
  localparam logic [7:0] GRAD_RESET = 8'h01;
  localparam logic [7:0] AMPL_RESET = 8'h80;
  localparam logic [19:0] THRS_RESET = 20'h0_0000;
  // ****************************************
  // timing counts in clock cycles, INIT_PERIODS in pwm periods
  // ****************************************
  localparam logic [10:0] PWM_DIV_00 = 11'h400;
  localparam logic [10:0] PWM_DIV_01 = 11'h2AB;
  localparam logic [10:0] PWM_DIV_10 = 11'h200;
  localparam logic [10:0] PWM_DIV_11 = 11'h19A;
  localparam logic [10:0] BLANK_00 = 11'h010;
  localparam logic [10:0] BLANK_01 = 11'h018;
  localparam logic [10:0] BLANK_10 = 11'h024;
  localparam logic [10:0] BLANK_11 = 11'h036;
  localparam logic [7:0] INIT_PERIODS = 8'h80;
  localparam int STANDSTILL_CLKS_DEF = 1048576;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_OTHER,
    MODE_QUIET
  } qvr_mode_type;
endpackage

// [src/qvr_divider.sv]
// Purpose: serial restoring divider, one quotient bit per cycle
// Assumes: start only while not busy
// Notes: divide by zero gives all ones
`timescale 1ns/1ps
module qvr_divider #(
  parameter int NUM_W = 16,
  parameter int DEN_W = 20
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // request
  input wire logic start_in,
  input wire logic [NUM_W-1:0] numer_in,
  input wire logic [DEN_W-1:0] denom_in,
  // answer
  output logic [NUM_W-1:0] quot_out,
  output logic done_out
);
  logic [NUM_W-1:0] quo_ff;
  logic [DEN_W-1:0] rem_ff;
  logic [DEN_W-1:0] den_ff;
  logic [5:0] cnt_ff;
  logic done_ff;
  logic [DEN_W:0] trial;

  assign trial = {rem_ff, quo_ff[NUM_W-1]};

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      quo_ff <= '0;
      rem_ff <= '0;
      den_ff <= '0;
      cnt_ff <= 6'h00;
    end else if (start_in && cnt_ff == 6'h00) begin
      quo_ff <= numer_in;
      rem_ff <= '0;
      den_ff <= denom_in;
      cnt_ff <= 6'(NUM_W);
    end else if (cnt_ff != 6'h00) begin
      cnt_ff <= cnt_ff - 6'h01;
      if (trial >= {1'b0, den_ff}) begin
        rem_ff <= DEN_W'(trial - {1'b0, den_ff});
        quo_ff <= {quo_ff[NUM_W-2:0], 1'b1};
      end else begin
        rem_ff <= trial[DEN_W-1:0];
        quo_ff <= {quo_ff[NUM_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (cnt_ff == 6'h01);
    end
  end

  assign quot_out = quo_ff;
  assign done_out = done_ff;
endmodule

// [src/qvr_pwm_timer.sv]
// Purpose: pwm period counter with selectable divisor
// Assumes: divisor select may change at any time
// Notes: period_end_out marks the last cycle of a period
`timescale 1ns/1ps
module qvr_pwm_timer (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // control
  input wire logic [1:0] freq_sel_in,
  // status
  output logic [10:0] count_out,
  output logic [10:0] divisor_out,
  output logic period_end_out
);
  import qvr_pkg::*;
  logic [10:0] cnt_ff;
  logic [10:0] div;

  always_comb begin
    case (freq_sel_in)
      2'b00: div = PWM_DIV_00;
      2'b01: div = PWM_DIV_01;
      2'b10: div = PWM_DIV_10;
      default: div = PWM_DIV_11;
    endcase
  end

  // >= so a smaller divisor never lets the count run away
  assign period_end_out = (cnt_ff >= div - 11'h001);
  assign count_out = cnt_ff;
  assign divisor_out = div;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_ff <= 11'h000;
    end else if (period_end_out) begin
      cnt_ff <= 11'h000; // [R4] [R23]
    end else begin
      cnt_ff <= cnt_ff + 11'h001; // [R23]
    end
  end
endmodule

// [src/qvr_quiet_pwm_regulator.sv]
// Purpose: voltage mode pwm amplitude regulator for the quiet chopper mode
// Assumes: step and comparator come from pins; bridge logic outside
// Notes: amplitude updates once per pwm period
// Contract
// R1 - autoscale bit picks feedback or feed-forward
// R2 - feed-forward measures nothing, ignores supply/stall
// R3 - feed-forward ignores current setting changes
// R4 - frequency code divides clock by 1024/683/512/410
// R5 - auto mode samples current in on phase
// R6 - gradient is the proportional regulator gain
// R7 - software prefers gain one
// R8 - no measurement when on time below blanking
// R9 - too low amplitude recovers at standstill
// R10 - quiet mode only below velocity threshold
// R11 - returning to quiet starts at base amplitude
// R12 - software picks base amplitude sensibly
// R13 - initial regulation only at standstill
// R14 - controller waits for stable amplitude
// R15 - software prefers automatic regulation
// R16 - very low current needs feed-forward or freewheel
// R17 - regulator also works during deceleration
// R18 - software retunes divider, blanking, current
// R19 - feed-forward amplitude is base plus gradient term
// R20 - regulation state kept while other mode runs
// R21 - controller holds still for 128 periods
// R22 - amplitude is 8 bits, saturating
// R23 - period counter restarts at selected divisor
`timescale 1ns/1ps
module qvr_quiet_pwm_regulator #(
  parameter int STANDSTILL_CLKS = qvr_pkg::STANDSTILL_CLKS_DEF
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // avalon-mm slave
  input wire logic [qvr_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // pins
  input wire logic step_in,
  input wire logic current_reached_in,
  // bridge side
  output logic pwm_on_out,
  output logic freewheel_out,
  output logic measure_enable_out,
  output logic quiet_active_out,
  output logic [7:0] pwm_scale_out
);
  import qvr_pkg::*;

  localparam int IDLE_W = $clog2(STANDSTILL_CLKS + 1);

  // ****************************************
  // registers
  // ****************************************
  logic [5:0] ctrl_ff;
  logic [7:0] regulation_gradient_ff;
  logic [7:0] base_voltage_amplitude_ff;
  logic [TSTEP_W-1:0] quiet_mode_velocity_threshold_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rdata_mux;
  logic bus_req;
  logic auto_mode;
  logic freewheel_en;
  logic [1:0] chopper_frequency_divider_select;
  logic [1:0] comparator_blanking_time;

  assign auto_mode = ctrl_ff[CTRL_AUTO_BIT];
  assign chopper_frequency_divider_select = ctrl_ff[CTRL_FREQ_LSB +: 2];
  assign freewheel_en = ctrl_ff[CTRL_FREEWHEEL_BIT];
  assign comparator_blanking_time = ctrl_ff[CTRL_BLANK_LSB +: 2];

  // one wait cycle: data registered, answer on the second cycle
  assign bus_req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_req & ~ack_ff;
  assign avs_readdata_out = rdata_ff;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_ff <= CTRL_RESET;
      regulation_gradient_ff <= GRAD_RESET;
      base_voltage_amplitude_ff <= AMPL_RESET;
      quiet_mode_velocity_threshold_ff <= THRS_RESET;
    end else if (avs_write_in && ack_ff) begin
      case (avs_address_in)
        ADDR_CTRL: ctrl_ff <= avs_writedata_in[5:0];
        ADDR_GRAD: regulation_gradient_ff <= avs_writedata_in[7:0];
        ADDR_AMPL: base_voltage_amplitude_ff <= avs_writedata_in[7:0];
        ADDR_THRS: quiet_mode_velocity_threshold_ff <= avs_writedata_in[TSTEP_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] pin_raw;
  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic [1:0] sync3_ff;
  logic [1:0] pin_ff;

  assign pin_raw = {current_reached_in, step_in};

  generate
    for (genvar gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          sync3_ff[gi] <= 1'b0;
          pin_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          if (sync2_ff[gi] == sync3_ff[gi]) begin
            pin_ff[gi] <= sync3_ff[gi];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // step period and standstill
  // ****************************************
  logic step_prev_ff;
  logic step_pulse;
  logic [TSTEP_W-1:0] gap_ff;
  logic [TSTEP_W-1:0] tstep_ff;
  logic [IDLE_W-1:0] idle_ff;
  logic standstill;

  assign step_pulse = pin_ff[0] & ~step_prev_ff;
  assign standstill = (idle_ff == IDLE_W'(STANDSTILL_CLKS));

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      step_prev_ff <= 1'b0;
      gap_ff <= '0;
      tstep_ff <= '1;
      idle_ff <= IDLE_W'(STANDSTILL_CLKS);
    end else begin
      step_prev_ff <= pin_ff[0];
      if (step_pulse) begin
        gap_ff <= '0;
        tstep_ff <= gap_ff;
        idle_ff <= '0;
      end else begin
        if (gap_ff != '1) begin
          gap_ff <= gap_ff + TSTEP_W'(1);
        end
        if (!standstill) begin
          idle_ff <= idle_ff + IDLE_W'(1);
        end else begin
          // no steps: velocity reads as the slowest possible
          tstep_ff <= '1;
        end
      end
    end
  end

  // ****************************************
  // pwm period and on phase
  // ****************************************
  logic [10:0] pwm_cnt;
  logic [10:0] pwm_div;
  logic period_end;
  logic [7:0] scale_ff;
  logic [18:0] on_limit;
  logic on_phase;
  logic [10:0] blank_cnt;
  logic measuring;
  qvr_mode_type mode_ff;

  qvr_pwm_timer u_timer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .freq_sel_in(chopper_frequency_divider_select),
    .count_out(pwm_cnt),
    .divisor_out(pwm_div),
    .period_end_out(period_end)
  );

  always_comb begin
    case (comparator_blanking_time)
      2'b00: blank_cnt = BLANK_00;
      2'b01: blank_cnt = BLANK_01;
      2'b10: blank_cnt = BLANK_10;
      default: blank_cnt = BLANK_11;
    endcase
  end

  // duty is scale/256 of the selected period
  assign on_limit = 19'(scale_ff) * 19'(pwm_div);
  assign on_phase = ({pwm_cnt, 8'h00} < on_limit) && (mode_ff == MODE_QUIET);
  assign measuring = auto_mode && on_phase && (pwm_cnt >= blank_cnt); // [R2] [R5] [R8]

  // ****************************************
  // measurement per period
  // ****************************************
  logic reached_ff;
  logic valid_ff;
  logic reached_now;
  logic valid_now;

  assign reached_now = reached_ff | (measuring & pin_ff[1]);
  assign valid_now = valid_ff | measuring;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reached_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else if (period_end) begin
      reached_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else begin
      reached_ff <= reached_now; // [R5]
      valid_ff <= valid_now; // [R8]
    end
  end

  // ****************************************
  // feed-forward term
  // ****************************************
  logic [15:0] ff_quot;
  logic ff_done;
  logic [8:0] ff_sum;

  qvr_divider #(
    .NUM_W(16),
    .DEN_W(TSTEP_W)
  ) u_div (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .start_in(period_end & ~auto_mode),
    .numer_in({regulation_gradient_ff, 8'h00}),
    .denom_in(tstep_ff),
    .quot_out(ff_quot),
    .done_out(ff_done)
  );

  assign ff_sum = {1'b0, base_voltage_amplitude_ff} + {1'b0, ff_quot[7:0]}; // [R19]

  // ****************************************
  // mode and amplitude regulation
  // ****************************************
  logic quiet_ok;
  logic init_done_ff;
  logic [7:0] init_cnt_ff;
  logic [8:0] up_sum;
  logic [8:0] dn_diff;
  logic [7:0] scale_up;
  logic [7:0] scale_dn;
  logic reg_allowed;

  assign quiet_ok = (tstep_ff >= quiet_mode_velocity_threshold_ff); // [R10]
  assign up_sum = {1'b0, scale_ff} + {1'b0, regulation_gradient_ff}; // [R6]
  assign dn_diff = {1'b0, scale_ff} - {1'b0, regulation_gradient_ff};
  assign scale_up = up_sum[8] ? 8'hFF : up_sum[7:0]; // [R22]
  assign scale_dn = dn_diff[8] ? 8'h00 : dn_diff[7:0]; // [R22]
  assign reg_allowed = init_done_ff | standstill; // [R13]

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode_ff <= MODE_QUIET;
    end else begin
      case (mode_ff)
        MODE_QUIET: if (!quiet_ok) mode_ff <= MODE_OTHER; // [R10]
        // re-entry waits for a period start so blanking still leads the first on phase
        MODE_OTHER: if (quiet_ok && period_end) mode_ff <= MODE_QUIET;
        default: mode_ff <= MODE_QUIET;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      init_done_ff <= 1'b0;
      init_cnt_ff <= 8'h00;
    end else if (!auto_mode) begin
      init_done_ff <= 1'b0;
      init_cnt_ff <= 8'h00;
    end else if (period_end && mode_ff == MODE_QUIET && !init_done_ff) begin
      if (!standstill) begin
        init_cnt_ff <= 8'h00;
      end else if (init_cnt_ff == INIT_PERIODS - 8'h01) begin
        init_done_ff <= 1'b1; // [R13] [R21]
      end else begin
        init_cnt_ff <= init_cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      scale_ff <= 8'h00;
    end else if (mode_ff == MODE_OTHER) begin
      if (quiet_ok && period_end) begin
        scale_ff <= base_voltage_amplitude_ff; // [R11]
      end
      // otherwise the last value is simply held [R20]
    end else if (auto_mode) begin // [R1]
      if (period_end && reg_allowed) begin
        if (valid_now) begin
          scale_ff <= reached_now ? scale_dn : scale_up; // [R5] [R6] [R17]
        end else if (standstill) begin
          scale_ff <= scale_up; // [R9]
        end
      end
    end else if (ff_done) begin
      // no feedback path: supply, stall and current setting have no effect
      scale_ff <= (ff_sum[8] || ff_quot[15:8] != 8'h00) ? 8'hFF : ff_sum[7:0]; // [R1] [R2] [R3] [R19] [R22]
    end
  end

  // ****************************************
  // outputs and status
  // ****************************************
  logic fw_active;

  // freewheel at standstill allows currents below the measurable limit
  assign fw_active = freewheel_en & standstill & (mode_ff == MODE_QUIET); // [R16]

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pwm_on_out <= 1'b0;
      freewheel_out <= 1'b0;
      measure_enable_out <= 1'b0;
      quiet_active_out <= 1'b0;
      pwm_scale_out <= 8'h00;
    end else begin
      pwm_on_out <= on_phase & ~fw_active;
      freewheel_out <= fw_active;
      measure_enable_out <= measuring & ~fw_active; // [R2]
      quiet_active_out <= (mode_ff == MODE_QUIET);
      pwm_scale_out <= scale_ff;
    end
  end

  always_comb begin
    rdata_mux = 32'h0000_0000;
    case (avs_address_in)
      ADDR_CTRL: rdata_mux[5:0] = ctrl_ff;
      ADDR_GRAD: rdata_mux[7:0] = regulation_gradient_ff;
      ADDR_AMPL: rdata_mux[7:0] = base_voltage_amplitude_ff;
      ADDR_THRS: rdata_mux[TSTEP_W-1:0] = quiet_mode_velocity_threshold_ff;
      ADDR_STATUS: begin
        rdata_mux[7:0] = scale_ff;
        rdata_mux[STAT_QUIET_BIT] = (mode_ff == MODE_QUIET);
        rdata_mux[STAT_STILL_BIT] = standstill;
        rdata_mux[STAT_INIT_BIT] = init_done_ff;
      end
      ADDR_TSTEP: rdata_mux[TSTEP_W-1:0] = tstep_ff;
      default: rdata_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read_in && !ack_ff) begin
      rdata_ff <= rdata_mux;
    end
  end
endmodule
